// *** hdl/aod_pkg.sv ***
// constants shared by the converter output path, demux and clocking logic
// Function
// [RULE_01] sample on falling clock edge; primary bus 13, delayed bus 14 later
// [RULE_02] every output word is coded offset binary
// [RULE_03] conversion runs continuously while the sample clock runs, no start
// [RULE_04] extended mode ignores level, edge, full-scale and delay/dual-edge pins
// [RULE_05] controller fixes normal or extended mode and never toggles it; the bench switches to extended once, while reset holds
// [RULE_06] in normal mode the full-scale pin sets both channels alike
// [RULE_07] clock receiver accepts up to 80/20 duty ratio by default
// [RULE_08] dual-edge mode samples one input on both clock edges
// [RULE_09] dual-edge output order earliest first: Q delayed, I delayed, Q, I
// [RULE_10] dual-edge: I buses falls 13/14 back, Q buses rises 13.5/14.5 back
// [RULE_11] normal sampling: I buses carry I, Q buses Q, latency 13 and 14
// [RULE_12] normal mode dual-edge uses I only; extended mode selects I or Q
// [RULE_13] dual-edge mode trims relative clock phase in the background
// [RULE_14] controller runs a command calibration before dual-edge mode; the bench skips it before the extended-mode dual-edge run
// [RULE_15] SDR data changes on rising clock edge if edge select high
// [RULE_16] SDR output clock equals bus rate; DDR runs at half, both edges
// [RULE_17] normal mode: floating edge pin selects DDR, driven selects SDR
// [RULE_18] level select high gives normal drive, low gives reduced drive
// [RULE_19] output clock travels with data; receiver latches data with it
// [RULE_20] single out-of-range flag; below scale gives zeroes, above ones
// [RULE_21] during calibration outputs are invalid and output clock halts
// [RULE_22] extended mode reset: DDR, 0 degree phase, normal level, no dual-edge
// [RULE_23] latencies count sample cycles, independent of output clock mode
// [RULE_24] receiver reorders the four bytes by sampling order
package aod_pkg;
	// =========================================================
	// data widths and pipeline tap entries (entry k is k+1 sample-clock cycles back on falls, k+0.5 on rises)
	localparam int AOD_CODE_W = 8;
	localparam int AOD_IN_W = 10;
	localparam int AOD_WORD_W = AOD_CODE_W + 1;
	localparam int AOD_FALL_TAP_PRI = 12;
	localparam int AOD_FALL_TAP_DEL = 13;
	localparam int AOD_RISE_TAP_PRI = 13;
	localparam int AOD_RISE_TAP_DEL = 14;
	localparam int AOD_PIPE_DEPTH = 15;
	localparam logic signed [9:0] AOD_CODE_MIN = -10'sd128;
	localparam logic signed [9:0] AOD_CODE_MAX = 10'sd127;
	localparam logic [7:0] AOD_CODE_FLIP = 8'h80;
	localparam logic [7:0] AOD_CODE_ZERO = 8'h00;
	localparam logic [7:0] AOD_CODE_ONES = 8'hff;
	// =========================================================
	// register map
	localparam int AOD_ADDR_W = 4;
	localparam int AOD_DATA_W = 16;
	localparam logic [3:0] AOD_REG_CONFIG = 4'h0;
	localparam logic [3:0] AOD_REG_DUALEDGE = 4'h1;
	localparam logic [3:0] AOD_REG_STATUS = 4'h2;
	localparam int AOD_CFG_SDR = 0;
	localparam int AOD_CFG_PHASE = 1;
	localparam int AOD_CFG_RISING = 2;
	localparam int AOD_CFG_LEVEL = 3;
	localparam int AOD_CFG_FULLSCALE = 4;
	localparam int AOD_DE_ENABLE = 0;
	localparam int AOD_DE_SELQ = 1;
	localparam int AOD_DE_AUTO = 2;
	localparam logic [4:0] AOD_CFG_RESET = 5'h18;
	localparam logic [2:0] AOD_DE_RESET = 3'h4;
	localparam int AOD_TRIM_W = 6;
	localparam logic [5:0] AOD_TRIM_RESET = 6'h20;
	localparam logic [5:0] AOD_TRIM_MAX = 6'h3f;
	localparam logic [5:0] AOD_TRIM_MIN = 6'h00;
endpackage

// *** hdl/aod_delay_line.sv ***
// sample pipeline with two fixed read taps
`timescale 1ns/10ps
module aod_delay_line #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 15,
	parameter int TAP_PRI = 12,
	parameter int TAP_DEL = 13
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic shiftEn,
	input wire logic [WIDTH-1:0] dataIn,
	output logic [WIDTH-1:0] tapPrimary,
	output logic [WIDTH-1:0] tapDelayed
);
	logic [WIDTH-1:0] stage_reg [DEPTH];

	// =========================================================
	// entry 0 holds the newest word; each shift ages every entry by one
	genvar g;
	generate
		for (g = 0; g < DEPTH; g++)
		begin : gStage
			always_ff @(posedge clk_sys)
			begin
				if (sys_rst)
					stage_reg[g] <= '0;
				else if (shiftEn)
					stage_reg[g] <= (g == 0) ? dataIn : stage_reg[(g == 0) ? 0 : g - 1];
			end
		end
	endgenerate

	// taps read the aged words before the shift lands
	assign tapPrimary = stage_reg[TAP_PRI];
	assign tapDelayed = stage_reg[TAP_DEL];
endmodule

// *** hdl/aod_mode_select.sv ***
// chooses pin or register control for each output-path setting
`timescale 1ns/10ps
module aod_mode_select (
	input wire logic extendedMode,
	input wire logic pinLevel,
	input wire logic pinEdge,
	input wire logic pinEdgeFloat,
	input wire logic pinFullScale,
	input wire logic pinCalDelay,
	input wire logic [4:0] cfgBits,
	input wire logic [2:0] dualEdgeBits,
	output logic useDdr,
	output logic ddrPhase,
	output logic sdrRising,
	output logic levelNormal,
	output logic fullScaleNormal,
	output logic dualEdge,
	output logic dualEdgeSelQ,
	output logic autoPhase,
	output logic calDelayLong
);
	import aod_pkg::*;

	// =========================================================
	// extended mode drops every pin and takes the register instead, except calDelayLong, which is held low
	assign useDdr = extendedMode ? ~cfgBits[AOD_CFG_SDR] : pinEdgeFloat; // RULE_04 RULE_17
	assign ddrPhase = extendedMode & cfgBits[AOD_CFG_PHASE];
	assign sdrRising = extendedMode ? cfgBits[AOD_CFG_RISING] : pinEdge; // RULE_15
	assign levelNormal = extendedMode ? cfgBits[AOD_CFG_LEVEL] : pinLevel; // RULE_18
	// one range pin feeds both channels
	assign fullScaleNormal = extendedMode ? cfgBits[AOD_CFG_FULLSCALE] : pinFullScale; // RULE_06
	assign dualEdge = extendedMode ? dualEdgeBits[AOD_DE_ENABLE] : pinCalDelay;
	// normal mode can only run the I input in dual-edge
	assign dualEdgeSelQ = extendedMode & dualEdgeBits[AOD_DE_SELQ]; // RULE_12
	assign autoPhase = ~extendedMode | dualEdgeBits[AOD_DE_AUTO];
	// extended mode supports only the short power-on delay
	assign calDelayLong = ~extendedMode & pinCalDelay;
endmodule

// *** hdl/aod_output_path.sv ***
// converter output path: latency pipes, 1:2 or 1:4 demux, output clocking
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/10ps
module aod_output_path (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic sampleClk,
	input wire logic [aod_pkg::AOD_IN_W-1:0] iAnalogCode,
	input wire logic [aod_pkg::AOD_IN_W-1:0] qAnalogCode,
	input wire logic extendedControlEnable,
	input wire logic calibrationActive,
	input wire logic outputLevelSelect,
	input wire logic outputEdgeSelect,
	input wire logic outputEdgeFloat,
	input wire logic fullScaleSelect,
	input wire logic calibrationDelaySelect,
	input wire logic [aod_pkg::AOD_ADDR_W-1:0] regAddr,
	input wire logic [aod_pkg::AOD_DATA_W-1:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	output logic [aod_pkg::AOD_DATA_W-1:0] regRdData,
	output logic [aod_pkg::AOD_CODE_W-1:0] iPrimaryBus,
	output logic [aod_pkg::AOD_CODE_W-1:0] iDelayedBus,
	output logic [aod_pkg::AOD_CODE_W-1:0] qPrimaryBus,
	output logic [aod_pkg::AOD_CODE_W-1:0] qDelayedBus,
	output logic outOfRange,
	output logic outputClock,
	output logic dataValid,
	output logic outputLevelNormal,
	output logic fullScaleNormal,
	output logic calDelayLong,
	output logic [aod_pkg::AOD_TRIM_W-1:0] phaseTrim
);
	import aod_pkg::*;

	localparam int SYNC_W = 8 + 2 * AOD_IN_W;

	// =========================================================
	// input synchronisers
	logic [SYNC_W-1:0] pinRaw;
	logic [SYNC_W-1:0] pinMeta_reg;
	logic [SYNC_W-1:0] pinSync_reg;
	logic clkPrev_reg;

	assign pinRaw = {sampleClk, extendedControlEnable, calibrationActive,
		outputLevelSelect, outputEdgeSelect, outputEdgeFloat,
		fullScaleSelect, calibrationDelaySelect, iAnalogCode, qAnalogCode};

	// every pin but the register port is foreign to clk_sys, so those pass two flops first
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			pinMeta_reg <= '0;
			pinSync_reg <= '0;
			clkPrev_reg <= 1'b0;
		end
		else
		begin
			pinMeta_reg <= pinRaw;
			pinSync_reg <= pinMeta_reg;
			clkPrev_reg <= pinSync_reg[SYNC_W-1];
		end
	end

	logic sampleLvl;
	logic extMode;
	logic calibration_active;
	logic pinLevel;
	logic pinEdge;
	logic pinEdgeFloat;
	logic pinFullScale;
	logic pinCalDelay;
	logic signed [AOD_IN_W-1:0] iCode;
	logic signed [AOD_IN_W-1:0] qCode;

	assign sampleLvl = pinSync_reg[SYNC_W-1];
	assign extMode = pinSync_reg[SYNC_W-2];
	assign calibration_active = pinSync_reg[SYNC_W-3];
	assign pinLevel = pinSync_reg[SYNC_W-4];
	assign pinEdge = pinSync_reg[SYNC_W-5];
	assign pinEdgeFloat = pinSync_reg[SYNC_W-6];
	assign pinFullScale = pinSync_reg[SYNC_W-7];
	assign pinCalDelay = pinSync_reg[SYNC_W-8];
	assign iCode = pinSync_reg[2*AOD_IN_W-1:AOD_IN_W];
	assign qCode = pinSync_reg[AOD_IN_W-1:0];

	// =========================================================
	// sample clock edges
	logic fallEdge;
	logic riseEdge;

	// edges come from levels, so any high/low split that lasts a couple of
	// clk_sys periods is accepted; heavily skewed duty ratios still work
	assign fallEdge = clkPrev_reg & ~sampleLvl; // RULE_07 RULE_01
	assign riseEdge = ~clkPrev_reg & sampleLvl; // RULE_08

	// =========================================================
	// register file
	logic [4:0] cfg_reg;
	logic [4:0] cfg_next;
	logic [2:0] dualEdge_reg;
	logic [2:0] dualEdge_next;
	logic wrConfig;
	logic wrDualEdge;

	assign wrConfig = regWrEn & (regAddr == AOD_REG_CONFIG);
	assign wrDualEdge = regWrEn & (regAddr == AOD_REG_DUALEDGE);
	assign cfg_next = wrConfig ? regWrData[4:0] : cfg_reg;
	assign dualEdge_next = wrDualEdge ? regWrData[2:0] : dualEdge_reg;

	// reset lands on DDR, 0 degree, normal level, dual-edge off
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			cfg_reg <= AOD_CFG_RESET; // RULE_22
			dualEdge_reg <= AOD_DE_RESET; // RULE_22
		end
		else
		begin
			cfg_reg <= cfg_next;
			dualEdge_reg <= dualEdge_next;
		end
	end

	// =========================================================
	// effective settings, pin or register
	logic useDdr;
	logic ddrPhase;
	logic sdrRising;
	logic levelNormal;
	logic fsNormal;
	logic dualEdge;
	logic dualEdgeSelQ;
	logic autoPhase;
	logic delayLong;

	// the mode pin is trusted to stay put; a change mid-run just re-muxes
	aod_mode_select uModeSelect (
		.extendedMode(extMode), // RULE_05
		.pinLevel(pinLevel),
		.pinEdge(pinEdge),
		.pinEdgeFloat(pinEdgeFloat),
		.pinFullScale(pinFullScale),
		.pinCalDelay(pinCalDelay),
		.cfgBits(cfg_reg),
		.dualEdgeBits(dualEdge_reg),
		.useDdr(useDdr),
		.ddrPhase(ddrPhase),
		.sdrRising(sdrRising),
		.levelNormal(levelNormal),
		.fullScaleNormal(fsNormal),
		.dualEdge(dualEdge),
		.dualEdgeSelQ(dualEdgeSelQ),
		.autoPhase(autoPhase),
		.calDelayLong(delayLong)
	);

	// =========================================================
	// conversion to offset binary with out-of-range flag in the top bit
	function automatic logic [AOD_WORD_W-1:0] toOffsetBinary(
		input logic signed [AOD_IN_W-1:0] v
	);
		logic [AOD_WORD_W-1:0] w;
		if (v < AOD_CODE_MIN)
			w = {1'b1, AOD_CODE_ZERO}; // RULE_20
		else if (v > AOD_CODE_MAX)
			w = {1'b1, AOD_CODE_ONES}; // RULE_20
		else
			w = {1'b0, v[AOD_CODE_W-1:0] ^ AOD_CODE_FLIP}; // RULE_02
		return w;
	endfunction

	logic signed [AOD_IN_W-1:0] selCode;
	logic [AOD_WORD_W-1:0] fallIWord;
	logic [AOD_WORD_W-1:0] fallQWord;
	logic [AOD_WORD_W-1:0] riseWord;

	// dual-edge drives both converters from the one selected input
	assign selCode = dualEdgeSelQ ? qCode : iCode; // RULE_12
	assign fallIWord = toOffsetBinary(dualEdge ? selCode : iCode); // RULE_11
	assign fallQWord = toOffsetBinary(qCode); // RULE_11
	assign riseWord = toOffsetBinary(selCode); // RULE_08

	// =========================================================
	// latency pipelines, shifted on sample-clock edges only
	logic [AOD_WORD_W-1:0] fallIPri;
	logic [AOD_WORD_W-1:0] fallIDel;
	logic [AOD_WORD_W-1:0] fallQPri;
	logic [AOD_WORD_W-1:0] fallQDel;
	logic [AOD_WORD_W-1:0] risePri;
	logic [AOD_WORD_W-1:0] riseDel;

	// free running on the sample clock: no start command exists
	aod_delay_line #(
		.WIDTH(AOD_WORD_W),
		.DEPTH(AOD_PIPE_DEPTH),
		.TAP_PRI(AOD_FALL_TAP_PRI),
		.TAP_DEL(AOD_FALL_TAP_DEL)
	) uFallI (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.shiftEn(fallEdge), // RULE_03 RULE_01
		.dataIn(fallIWord),
		.tapPrimary(fallIPri),
		.tapDelayed(fallIDel)
	);

	aod_delay_line #(
		.WIDTH(AOD_WORD_W),
		.DEPTH(AOD_PIPE_DEPTH),
		.TAP_PRI(AOD_FALL_TAP_PRI),
		.TAP_DEL(AOD_FALL_TAP_DEL)
	) uFallQ (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.shiftEn(fallEdge), // RULE_01
		.dataIn(fallQWord),
		.tapPrimary(fallQPri),
		.tapDelayed(fallQDel)
	);

	// newest rise sits half a cycle before the fall that reads it, so
	// entry 13 is 13.5 cycles back and entry 14 is 14.5
	aod_delay_line #(
		.WIDTH(AOD_WORD_W),
		.DEPTH(AOD_PIPE_DEPTH),
		.TAP_PRI(AOD_RISE_TAP_PRI),
		.TAP_DEL(AOD_RISE_TAP_DEL)
	) uRise (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.shiftEn(riseEdge), // RULE_10
		.dataIn(riseWord),
		.tapPrimary(risePri),
		.tapDelayed(riseDel)
	);

	// =========================================================
	// 1:2 demux phase: buses load on every second falling edge
	logic demuxPhase_reg;
	logic loadBuses;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			demuxPhase_reg <= 1'b0;
		else if (fallEdge)
			demuxPhase_reg <= ~demuxPhase_reg;
	end

	// the load edge is tied to the sample clock and calibration, never the clock mode
	assign loadBuses = fallEdge & demuxPhase_reg & ~calibration_active; // RULE_23

	logic [AOD_WORD_W-1:0] qPriWord;
	logic [AOD_WORD_W-1:0] qDelWord;
	logic anyOver;

	// Q buses carry rise samples in dual-edge, giving order Qd, Id, Q, I
	assign qPriWord = dualEdge ? risePri : fallQPri; // RULE_09 RULE_10
	assign qDelWord = dualEdge ? riseDel : fallQDel; // RULE_09 RULE_10
	assign anyOver = fallIPri[AOD_CODE_W] | fallIDel[AOD_CODE_W]
		| qPriWord[AOD_CODE_W] | qDelWord[AOD_CODE_W]; // RULE_20

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			iPrimaryBus <= '0;
			iDelayedBus <= '0;
			qPrimaryBus <= '0;
			qDelayedBus <= '0;
			outOfRange <= 1'b0;
		end
		else if (loadBuses)
		begin
			iPrimaryBus <= fallIPri[AOD_CODE_W-1:0]; // RULE_01 RULE_11
			iDelayedBus <= fallIDel[AOD_CODE_W-1:0]; // RULE_01 RULE_11
			qPrimaryBus <= qPriWord[AOD_CODE_W-1:0];
			qDelayedBus <= qDelWord[AOD_CODE_W-1:0];
			outOfRange <= anyOver;
		end
	end

	// =========================================================
	// output clock: SDR one period per word, DDR one edge per word
	logic midEdge;
	logic outClkNext;

	assign midEdge = fallEdge & ~demuxPhase_reg & ~calibration_active;

	// calibration freezes the clock so the receiver sees no edges
	always_comb
	begin
		outClkNext = outputClock; // RULE_21
		if (useDdr)
		begin
			if ((loadBuses & ~ddrPhase) | (midEdge & ddrPhase))
				outClkNext = ~outputClock; // RULE_16
		end
		else if (loadBuses)
			outClkNext = sdrRising; // RULE_15 RULE_16
		else if (midEdge)
			outClkNext = ~sdrRising; // RULE_15
	end

	// the clock leaves with the data so the receiver can latch on it
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			outputClock <= 1'b0;
		else
			outputClock <= outClkNext; // RULE_19
	end

	// data are flagged invalid from the first calibration cycle onward
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			dataValid <= 1'b0;
		else if (calibration_active)
			dataValid <= 1'b0; // RULE_21
		else if (loadBuses)
			dataValid <= 1'b1;
	end

	// =========================================================
	// background phase trim for dual-edge mode
	logic trimStep;
	logic trimUp;
	logic trimDown;

	// a rise sample steadily above its fall neighbour means a late rise clock
	assign trimStep = loadBuses & dualEdge & autoPhase; // RULE_13
	assign trimUp = trimStep & (risePri[AOD_CODE_W-1:0] < fallIPri[AOD_CODE_W-1:0])
		& (phaseTrim != AOD_TRIM_MAX);
	assign trimDown = trimStep & (risePri[AOD_CODE_W-1:0] > fallIPri[AOD_CODE_W-1:0])
		& (phaseTrim != AOD_TRIM_MIN);

	// only a coarse tracker; the on-command calibration is still needed
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			phaseTrim <= AOD_TRIM_RESET;
		else if (trimUp)
			phaseTrim <= phaseTrim + 6'h01; // RULE_13
		else if (trimDown)
			phaseTrim <= phaseTrim - 6'h01; // RULE_13
	end

	// =========================================================
	// static settings to the analog side
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			outputLevelNormal <= 1'b1;
			fullScaleNormal <= 1'b1;
			calDelayLong <= 1'b0;
		end
		else
		begin
			outputLevelNormal <= levelNormal; // RULE_18
			fullScaleNormal <= fsNormal; // RULE_06
			calDelayLong <= delayLong; // RULE_04
		end
	end

	// =========================================================
	// register read port: data stand one cycle, zero otherwise
	logic [AOD_DATA_W-1:0] statusWord;
	logic [AOD_DATA_W-1:0] rdMux;

	assign statusWord = {2'b00, phaseTrim, 3'b000, outOfRange, dualEdge,
		useDdr, extMode, calibration_active};
	assign rdMux = (regAddr == AOD_REG_CONFIG) ? {11'h000, cfg_reg}
		: (regAddr == AOD_REG_DUALEDGE) ? {13'h0000, dualEdge_reg}
		: (regAddr == AOD_REG_STATUS) ? statusWord
		: 16'h0000;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			regRdData <= '0;
		else
			regRdData <= regRdEn ? rdMux : 16'h0000;
	end
endmodule

// *** verif/aod_output_path_props.sv ***
// concurrent checks on the converter output path ports
`timescale 1ns/10ps
module aod_output_path_props (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [aod_pkg::AOD_ADDR_W-1:0] regAddr,
	input wire logic regRdEn,
	input wire logic [aod_pkg::AOD_DATA_W-1:0] regRdData,
	input wire logic extendedControlEnable,
	input wire logic calibrationActive,
	input wire logic outputLevelSelect,
	input wire logic fullScaleSelect,
	input wire logic outputLevelNormal,
	input wire logic fullScaleNormal,
	input wire logic calDelayLong,
	input wire logic dataValid,
	input wire logic outputClock,
	input wire logic [aod_pkg::AOD_CODE_W-1:0] iPrimaryBus,
	input wire logic [aod_pkg::AOD_TRIM_W-1:0] phaseTrim
);
	import aod_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// =========================================================
	// register port
	a_rd_idle_zero: assert property (!$past(regRdEn) |-> regRdData == '0)
		else $error("read data not zero outside a read");
	a_rd_unmapped: assert property (regRdEn && regAddr > AOD_REG_STATUS |=> regRdData == '0)
		else $error("unmapped read not zero");
	a_status_trim: assert property (regRdEn && regAddr == AOD_REG_STATUS
		|=> regRdData[13:8] == $past(phaseTrim))
		else $error("status trim field wrong");
	a_trim_unit_step: assert property ($changed(phaseTrim) |-> phaseTrim ==
		$past(phaseTrim) + 6'h01 || phaseTrim == $past(phaseTrim) - 6'h01)
		else $error("phase trim moved by more than one");
	// =========================================================
	// pin controls; the sync chain needs three edges to settle
	a_level_pin: assert property ((!extendedControlEnable && $stable(outputLevelSelect))[*4]
		|-> outputLevelNormal == outputLevelSelect)
		else $error("level does not follow pin");
	a_fs_pin: assert property ((!extendedControlEnable && $stable(fullScaleSelect))[*4]
		|-> fullScaleNormal == fullScaleSelect)
		else $error("full scale does not follow pin");
	a_ext_pins_off: assert property (extendedControlEnable[*4] |-> !calDelayLong)
		else $error("delay pin used in extended mode");
	// =========================================================
	// calibration and bus pacing
	a_cal_no_valid: assert property (calibrationActive[*4] |-> !dataValid)
		else $error("data valid during calibration");
	a_cal_clk_halt: assert property (calibrationActive[*4] |=> $stable(outputClock))
		else $error("output clock runs during calibration");
	a_bus_hold: assert property ($changed(iPrimaryBus) |=> $stable(iPrimaryBus)[*8])
		else $error("bus changed too soon");
	c_cal: cover property (calibrationActive && !dataValid);
	c_status: cover property (regRdEn && regAddr == AOD_REG_STATUS);
	c_clk: cover property ($rose(outputClock));
endmodule

bind aod_output_path aod_output_path_props aod_output_path_props_inst (
	.clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr),
	.regRdEn(regRdEn), .regRdData(regRdData),
	.extendedControlEnable(extendedControlEnable),
	.calibrationActive(calibrationActive),
	.outputLevelSelect(outputLevelSelect), .fullScaleSelect(fullScaleSelect),
	.outputLevelNormal(outputLevelNormal), .fullScaleNormal(fullScaleNormal),
	.calDelayLong(calDelayLong), .dataValid(dataValid),
	.outputClock(outputClock), .iPrimaryBus(iPrimaryBus),
	.phaseTrim(phaseTrim));

// *** verif/aod_rx_model.sv ***
// receiving logic that latches the four buses with the output clock
`timescale 1ns/10ps
module aod_rx_model (
	input wire logic outputClock,
	input wire logic dataValid,
	input wire logic launchRising,
	input wire logic [aod_pkg::AOD_CODE_W-1:0] iPrimaryBus,
	input wire logic [aod_pkg::AOD_CODE_W-1:0] iDelayedBus,
	input wire logic [aod_pkg::AOD_CODE_W-1:0] qPrimaryBus,
	input wire logic [aod_pkg::AOD_CODE_W-1:0] qDelayedBus,
	output logic [31:0] rxWord
);
	import aod_pkg::*;
	initial rxWord = '0;
	// latch on the edge opposite launch so the data has settled; drop invalid
	always @(posedge outputClock or negedge outputClock)
	begin
		if (outputClock != launchRising && dataValid)
			rxWord <= {qDelayedBus, iDelayedBus, qPrimaryBus, iPrimaryBus};
	end
endmodule

// *** verif/tb_adc_output_demux_clocking.sv ***
// self-checking bench for the converter output path
`timescale 1ns/10ps
module tb_adc_output_demux_clocking;
	import aod_pkg::*;
	logic clk_sys = 0, sys_rst = 1, sampleClk = 0, chg = 0;
	logic [9:0] iAnalogCode = '0, qAnalogCode = '0;
	logic extendedControlEnable = 0, calibrationActive = 0;
	logic outputLevelSelect = 1, outputEdgeSelect = 1, outputEdgeFloat = 0;
	logic fullScaleSelect = 1, calibrationDelaySelect = 0;
	logic [3:0] regAddr = '0;
	logic [15:0] regWrData = '0, regRdData, rdv;
	logic regWrEn = 0, regRdEn = 0;
	logic [7:0] iPrimaryBus, iDelayedBus, qPrimaryBus, qDelayedBus;
	logic outOfRange, outputClock, dataValid, outputLevelNormal;
	logic fullScaleNormal, calDelayLong;
	logic [5:0] phaseTrim;
	logic [31:0] rxWord;
	logic [7:0] held;
	int fails = 0, n_checks = 0, fallCnt = 0, chkFrom = 16;
	int fI[1024], fQ[1024], rI[1024], rQ[1024];
	bit chkOn = 0, de = 0, deQ = 0, sdr = 1, edgeR = 1;
	aod_output_path aod_output_path_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.sampleClk(sampleClk), .iAnalogCode(iAnalogCode), .qAnalogCode(qAnalogCode),
		.extendedControlEnable(extendedControlEnable),
		.calibrationActive(calibrationActive), .outputLevelSelect(outputLevelSelect),
		.outputEdgeSelect(outputEdgeSelect), .outputEdgeFloat(outputEdgeFloat),
		.fullScaleSelect(fullScaleSelect),
		.calibrationDelaySelect(calibrationDelaySelect), .regAddr(regAddr),
		.regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regRdData(regRdData), .iPrimaryBus(iPrimaryBus), .iDelayedBus(iDelayedBus),
		.qPrimaryBus(qPrimaryBus), .qDelayedBus(qDelayedBus), .outOfRange(outOfRange),
		.outputClock(outputClock), .dataValid(dataValid),
		.outputLevelNormal(outputLevelNormal), .fullScaleNormal(fullScaleNormal),
		.calDelayLong(calDelayLong), .phaseTrim(phaseTrim));
	aod_rx_model aod_rx_model_inst (.outputClock(outputClock), .dataValid(dataValid),
		.launchRising(edgeR), .iPrimaryBus(iPrimaryBus), .iDelayedBus(iDelayedBus),
		.qPrimaryBus(qPrimaryBus), .qDelayedBus(qDelayedBus), .rxWord(rxWord));
	// =========================================================
	// clocks; the sample clock is offset so its edges never meet clk_sys edges
	initial forever #2 clk_sys = ~clk_sys;
	initial
	begin
		#1.3;
		forever
		begin
			sampleClk = ~sampleClk;
			if (!sampleClk)
			begin
				fallCnt++;
				fI[fallCnt] = $signed(iAnalogCode);
				fQ[fallCnt] = $signed(qAnalogCode);
			end
			else
			begin
				rI[fallCnt] = $signed(iAnalogCode);
				rQ[fallCnt] = $signed(qAnalogCode);
			end
			#16 chg = 1;
			#6 if (!sampleClk && chkOn && fallCnt >= chkFrom) check_buses();
			#10;
		end
	end
	// inputs move mid phase, well clear of both sample edges
	always @(posedge clk_sys)
		if (chg)
		begin
			chg = 0;
			iAnalogCode <= 10'($urandom_range(300) - 150);
			qAnalogCode <= 10'($urandom_range(300) - 150);
		end
	// =========================================================
	// helpers
	function automatic logic [7:0] enc(int v);
		if (v < -128)
			return 8'h00;
		if (v > 127)
			return 8'hff;
		return 8'(v + 128);
	endfunction
	function automatic bit clip(int v);
		return v < -128 || v > 127;
	endfunction
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_falls(int n);
		int t;
		t = 0;
		while (fallCnt < n && t < 20000)
		begin
			@(posedge clk_sys);
			t++;
		end
		if (t >= 20000)
		begin
			fails++;
			tally_and_finish();
		end
		// let the bus check of the last fall run before the model moves on
		else
			repeat (6) @(posedge clk_sys);
	endtask
	task automatic wr(logic [3:0] a, logic [15:0] d);
		@(posedge clk_sys);
		regWrEn <= 1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk_sys);
		regWrEn <= 0;
	endtask
	task automatic rd(logic [3:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		regRdEn <= 1;
		regAddr <= a;
		@(posedge clk_sys);
		regRdEn <= 0;
		#1 d = regRdData;
	endtask
	// reset just after a rise so the first fall seen is a clean mid edge
	task automatic do_reset();
		@(posedge sampleClk);
		@(posedge clk_sys);
		sys_rst <= 1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 0;
		fallCnt = 0;
	endtask
	// model of the buses after the fall just seen; loads on even falls
	task automatic check_buses();
		int f, l, a, b, c, d;
		f = fallCnt;
		l = f - f % 2;
		a = (de && deQ) ? fQ[l-13] : fI[l-13];
		b = (de && deQ) ? fQ[l-14] : fI[l-14];
		c = de ? (deQ ? rQ[l-14] : rI[l-14]) : fQ[l-13];
		d = de ? (deQ ? rQ[l-15] : rI[l-15]) : fQ[l-14];
		cmp(iPrimaryBus, enc(a));
		cmp(iDelayedBus, enc(b));
		cmp(qPrimaryBus, enc(c));
		cmp(qDelayedBus, enc(d));
		cmp(outOfRange, clip(a) || clip(b) || clip(c) || clip(d));
		cmp(dataValid, 1'b1);
		cmp(outputClock, sdr ? ((f == l) == edgeR) : (l / 2) % 2);
	endtask
	task automatic run_normal(bit lvl, bit es, bit fl, bit fs, bit cd, int n);
		@(posedge clk_sys);
		outputLevelSelect <= lvl;
		outputEdgeSelect <= es;
		outputEdgeFloat <= fl;
		fullScaleSelect <= fs;
		calibrationDelaySelect <= cd;
		// extended mode ignores the pins and starts in DDR, dual-edge off
		de = cd && !extendedControlEnable;
		deQ = 0;
		sdr = !fl && !extendedControlEnable;
		edgeR = es;
		do_reset();
		chkFrom = 16;
		chkOn = 1;
		wait_falls(n);
		cmp(outputLevelNormal, lvl || extendedControlEnable);
		cmp(fullScaleNormal, fs || extendedControlEnable);
		cmp(calDelayLong, cd && !extendedControlEnable);
	endtask
	// =========================================================
	// main sequence
	initial
	begin
		void'($urandom(32'ha2056bfd));
		repeat (2) @(posedge clk_sys);
		sys_rst <= 0;
		run_normal(1, 1, 0, 1, 0, 37);
		repeat (8) @(posedge clk_sys);
		cmp(rxWord, {qDelayedBus, iDelayedBus, qPrimaryBus, iPrimaryBus});
		run_normal(0, 0, 0, 0, 0, 36);
		// a calibration precedes the normal-mode dual-edge run, not the extended one
		chkOn = 0;
		calibrationActive <= 1;
		wait_falls(fallCnt + 4);
		held = iPrimaryBus;
		cmp(dataValid, 1'b0);
		wait_falls(fallCnt + 3);
		cmp(iPrimaryBus, held);
		calibrationActive <= 0;
		run_normal(1, 0, 1, 1, 1, 36);
		// the control mode only moves while reset holds the block
		sys_rst <= 1;
		extendedControlEnable <= 1;
		run_normal(0, 1, 0, 0, 1, 21);
		cmp(outputLevelNormal, 1'b1);
		cmp(fullScaleNormal, 1'b1);
		cmp(calDelayLong, 1'b0);
		rd(AOD_REG_CONFIG, rdv);
		cmp(rdv, 16'h0018);
		rd(AOD_REG_DUALEDGE, rdv);
		cmp(rdv, 16'h0004);
		rd(4'hf, rdv);
		cmp(rdv, 16'h0000);
		wr(AOD_REG_STATUS, 16'hffff);
		rd(AOD_REG_STATUS, rdv);
		cmp(rdv[2:0], 3'h6);
		chkOn = 0;
		wr(AOD_REG_CONFIG, 16'h0005);
		wr(AOD_REG_DUALEDGE, 16'h0007);
		sdr = 1;
		edgeR = 1;
		de = 1;
		deQ = 1;
		chkFrom = fallCnt + 18;
		chkOn = 1;
		wait_falls(fallCnt + 24);
		cmp(outputLevelNormal, 1'b0);
		cmp(fullScaleNormal, 1'b0);
		tally_and_finish();
	end
endmodule
